// ==== include/t1tx_defines.vh ====
// Purpose: constants for the T1 transmit digital output stage
// Assumes: 100 MHz aclk, AXI4-Lite register access
// Notes:   offsets are byte addresses
`ifndef T1TX_DEFINES_VH
`define T1TX_DEFINES_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define T1TX_A_CTRL     4'h0
`define T1TX_A_STAT     4'h4
`define T1TX_A_DLBITS   4'h8
`define T1TX_CTRL_RST   9'h000
// ----------------------------------------
// Control fields
// ----------------------------------------
`define T1TX_C_SRC_LO   0
`define T1TX_C_SRC_HI   1
`define T1TX_C_JAT      2
`define T1TX_C_DUAL     3
`define T1TX_C_RZ       4
`define T1TX_C_FALL     5
`define T1TX_C_FULL     6
`define T1TX_C_HDLC     7
`define T1TX_C_SF       8
// Status fields, W1C for the two flags
`define T1TX_S_SREQ     0
`define T1TX_S_UDR      1
// ----------------------------------------
// Clock sources and line-rate oscillator
// ----------------------------------------
`define T1TX_SRC_TXIN   2'h0
`define T1TX_SRC_RXREC  2'h1
`define T1TX_SRC_BPL    2'h2
// 2 x 1.544 MHz toggle rate over 100 MHz, 16-bit phase
`define T1TX_NCO_INC    16'h07e8
`define T1TX_NCO_TRIM   16'h0008
// ----------------------------------------
// FIFO and bus
// ----------------------------------------
`define T1TX_FIFO_W     2
`define T1TX_FIFO_D     4
`define T1TX_LVL_LOW    3'h1
`define T1TX_LVL_HIGH   3'h3
`define T1TX_RESP_OK    2'h0
`define T1TX_RESP_ERR   2'h2
`endif

// ==== hw/t1tx_out.v ====
// Overview of operation
// - The shared link pin gives the sample clock with HDLC off, else underrun.
// - Link serial input is captured when the sample clock rises.
// - In superframe format the sample clock stays low.
// - With HDLC on, underrun rises if the buffer empties while service is due.
// - A 1.544 MHz line clock times every digital line output.
// - The line clock comes from one of three sources, or with attenuation from an oscillator steered by FIFO fill.
// - Dual rail puts positive pulses on one pin and negative on the other.
// - Dual-rail pulses are either return-to-zero or non-return-to-zero.
// - Single rail puts data on the positive pin and the FIFO flag on the negative.
// - Outputs and flag update on the rising or the falling line clock edge.
// - The flag reports FIFO nearly empty or nearly full, as configured.
// - The service request rises once the last HDLC byte is set up.
//
// Purpose: transmit digital line output stage with AXI4-Lite control
// Assumes: clock source pins are asynchronous to aclk
// Notes:   rate FIFO sits between the bit source and the line
`timescale 1ns/1ps
`include "t1tx_defines.vh"

// ----------------------------------------
// Rate conversion FIFO
// ----------------------------------------
module t1tx_fifo #(
	parameter W = 2,
	parameter D = 4
)(
	input  wire         clk,
	input  wire         rst_n,
	// Fill side
	input  wire         in_valid,
	output reg          in_ready,
	input  wire [W-1:0] in_data,
	// Drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data,
	output reg  [2:0]   level
);
	reg  [W-1:0] mem [0:D-1];
	reg  [1:0]   wp_r;
	reg  [1:0]   rp_r;
	wire         push = in_valid && in_ready;
	wire         pop  = out_valid && out_ready;
	wire [2:0]   level_nxt = level + {2'h0, push} - {2'h0, pop};

	assign out_valid = (level != 3'h0);
	assign out_data  = mem[rp_r];

	// Pointers and fill level; ready is registered so it is honest
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wp_r     <= 2'h0;
			rp_r     <= 2'h0;
			level    <= 3'h0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				mem[wp_r] <= in_data;
				wp_r      <= wp_r + 2'h1;
			end
			if (pop)
				rp_r <= rp_r + 2'h1;
			level    <= level_nxt;
			in_ready <= (level_nxt < D[2:0]);
		end
	end
endmodule

// ----------------------------------------
// Top: line output stage
// ----------------------------------------
module t1tx_out (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write
	input  wire [3:0]  awaddr,
	input  wire        awvalid,
	output reg         awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output reg         wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	// AXI4-Lite read
	input  wire [3:0]  araddr,
	input  wire        arvalid,
	output reg         arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// Bit source (aclk domain): {negative, positive}
	input  wire        src_valid,
	input  wire [1:0]  src_bits,
	output reg         src_ready,
	input  wire        dl_slot,
	// HDLC transmitter status (aclk domain)
	input  wire        hdlc_last_loaded,
	input  wire        hdlc_buffer_empty,
	// Clock source pins
	input  wire        tx_clock_input,
	input  wire        recovered_rx_clock,
	input  wire        backplane_tx_clock,
	// Line pins
	output reg         tx_line_clock,
	output reg         tx_positive_pulse,
	output reg         tx_negative_pulse,
	// Data link pins
	input  wire        datalink_serial_in,
	output reg         datalink_shared_out,
	output reg         datalink_service_request
);
	reg  [8:0]  ctrl_r;
	reg  [3:0]  aw_addr_r;
	reg  [8:0]  w_data_r;
	reg  [1:0]  w_strb_r;
	reg  [3:0]  s1_r;
	reg  [3:0]  s2_r;
	reg  [15:0] nco_r;
	reg         nco_clk_r;
	reg         dl_clk_r;
	reg         underrun_r;
	reg  [7:0]  dl_bits_r;
	reg         mark_p_r;
	reg         mark_n_r;
	reg         sreq_clr;
	reg         udr_clr;
	reg         src_sel;
	reg  [15:0] inc;
	reg  [16:0] nco_sum;
	reg         clk_nxt;
	wire [3:0]  pins = {datalink_serial_in, backplane_tx_clock,
		recovered_rx_clock, tx_clock_input};
	wire        jat    = ctrl_r[`T1TX_C_JAT];
	wire        dual   = ctrl_r[`T1TX_C_DUAL];
	wire        rz     = ctrl_r[`T1TX_C_RZ];
	wire        fall   = ctrl_r[`T1TX_C_FALL];
	wire        hdlc   = ctrl_r[`T1TX_C_HDLC];
	wire        sf     = ctrl_r[`T1TX_C_SF];
	wire        f_valid;
	wire [1:0]  f_bits;
	wire [2:0]  f_lvl;
	wire        f_ready;
	wire        line_rise = clk_nxt && !tx_line_clock;
	wire        line_fall = !clk_nxt && tx_line_clock;
	wire        upd_edge  = fall ? line_fall : line_rise;
	wire        half_edge = fall ? line_rise : line_fall;
	wire        near_full = (f_lvl >= `T1TX_LVL_HIGH);
	wire        near_empty = (f_lvl <= `T1TX_LVL_LOW);
	wire        flag = ctrl_r[`T1TX_C_FULL] ? near_full : near_empty;
	wire        dl_ok = !hdlc && !sf && dl_slot;

	// ----------------------------------------
	// Pin synchronisers, two stages per pin
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : sync
			always @(posedge aclk)
			begin
				s1_r[g] <= pins[g];
				s2_r[g] <= s1_r[g];
			end
		end
	endgenerate

	// Source choice and oscillator step, trimmed by FIFO fill
	always @*
	begin
		case (ctrl_r[`T1TX_C_SRC_HI:`T1TX_C_SRC_LO])
			`T1TX_SRC_TXIN:  src_sel = s2_r[0];
			`T1TX_SRC_RXREC: src_sel = s2_r[1];
			`T1TX_SRC_BPL:   src_sel = s2_r[2];
			default:         src_sel = s2_r[0];
		endcase
		inc = `T1TX_NCO_INC;
		if (near_full)
			inc = `T1TX_NCO_INC + `T1TX_NCO_TRIM;
		else if (near_empty)
			inc = `T1TX_NCO_INC - `T1TX_NCO_TRIM;
		nco_sum = {1'b0, nco_r} + {1'b0, inc};
		clk_nxt = jat ? nco_clk_r : src_sel;
	end

	assign f_ready = upd_edge;

	t1tx_fifo #(
		.W (`T1TX_FIFO_W),
		.D (`T1TX_FIFO_D)
	) u_fifo (
		.clk       (aclk),
		.rst_n     (aresetn),
		.in_valid  (src_valid && src_ready), // Push only on handshake
		.in_ready  (),
		.in_data   (src_bits),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_bits),
		.level     (f_lvl)
	);

	// ----------------------------------------
	// Line clock and line outputs
	// ----------------------------------------
	// Attenuated clock ignores source jitter; FIFO fill steers its rate
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			nco_r             <= 16'h0000;
			nco_clk_r         <= 1'b0;
			tx_line_clock     <= 1'b0;
			mark_p_r          <= 1'b0;
			mark_n_r          <= 1'b0;
			tx_positive_pulse <= 1'b0;
			tx_negative_pulse <= 1'b0;
			src_ready         <= 1'b0;
		end
		else
		begin
			nco_r <= nco_sum[15:0];
			if (nco_sum[16])
				nco_clk_r <= !nco_clk_r;
			tx_line_clock <= clk_nxt;
			src_ready     <= (f_lvl < `T1TX_LVL_HIGH) ||
				(f_lvl == `T1TX_LVL_HIGH && !src_valid);
			if (upd_edge)
			begin
				// Underflow sends a space rather than stale data
				mark_p_r <= f_valid && f_bits[0];
				mark_n_r <= f_valid && f_bits[1];
				if (dual)
				begin
					tx_positive_pulse <= f_valid && f_bits[0];
					tx_negative_pulse <= f_valid && f_bits[1];
				end
				else
				begin
					tx_positive_pulse <= f_valid && |f_bits;
					tx_negative_pulse <= flag;
				end
			end
			else if (half_edge && dual && rz)
			begin
				tx_positive_pulse <= 1'b0;
				tx_negative_pulse <= 1'b0;
			end
			else if (half_edge && dual)
			begin
				tx_positive_pulse <= mark_p_r;
				tx_negative_pulse <= mark_n_r;
			end
		end
	end

	// ----------------------------------------
	// Data link clock, capture and HDLC flags
	// ----------------------------------------
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dl_clk_r                 <= 1'b0;
			dl_bits_r                <= 8'h00;
			underrun_r               <= 1'b0;
			datalink_service_request <= 1'b0;
			datalink_shared_out      <= 1'b0;
		end
		else
		begin
			if (sf || hdlc)
				dl_clk_r <= 1'b0;
			else if (upd_edge && dl_ok)
			begin
				dl_clk_r  <= 1'b1;
				// Source must hold its bit valid here
				dl_bits_r <= {dl_bits_r[6:0], s2_r[3]};
			end
			else if (half_edge)
				dl_clk_r <= 1'b0;
			// Set wins over a clear in the same cycle
			if (hdlc && hdlc_last_loaded)
				datalink_service_request <= 1'b1;
			else if (sreq_clr)
				datalink_service_request <= 1'b0;
			if (hdlc && hdlc_buffer_empty && datalink_service_request)
				underrun_r <= 1'b1;
			else if (udr_clr)
				underrun_r <= 1'b0;
			datalink_shared_out <= hdlc ? underrun_r : dl_clk_r;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	wire wr_go = !awready && !wready && !bvalid;

	always @*
	begin
		sreq_clr = wr_go && aw_addr_r == `T1TX_A_STAT && w_strb_r[0] &&
			w_data_r[`T1TX_S_SREQ];
		udr_clr  = wr_go && aw_addr_r == `T1TX_A_STAT && w_strb_r[0] &&
			w_data_r[`T1TX_S_UDR];
	end

	// Address and data taken in either order; response after both
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			bvalid    <= 1'b0;
			bresp     <= `T1TX_RESP_OK;
			aw_addr_r <= 4'h0;
			w_data_r  <= 9'h000;
			w_strb_r  <= 2'h0;
			ctrl_r    <= `T1TX_CTRL_RST;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready   <= 1'b0;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				// Master may change data once taken, so keep it
				wready   <= 1'b0;
				w_data_r <= wdata[8:0];
				w_strb_r <= wstrb[1:0];
			end
			if (wr_go)
			begin
				bvalid <= 1'b1;
				bresp  <= `T1TX_RESP_OK;
				if (aw_addr_r == `T1TX_A_CTRL)
				begin
					if (w_strb_r[0])
						ctrl_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1])
						ctrl_r[8] <= w_data_r[8];
				end
				else if (aw_addr_r != `T1TX_A_STAT)
					bresp <= `T1TX_RESP_ERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Read path, one cycle after the address is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `T1TX_RESP_OK;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `T1TX_RESP_OK;
			case (araddr)
				`T1TX_A_CTRL:   rdata <= {23'h0, ctrl_r};
				`T1TX_A_STAT:   rdata <= {24'h0, near_full, near_empty,
					f_lvl, dl_clk_r, underrun_r, datalink_service_request};
				`T1TX_A_DLBITS: rdata <= {24'h0, dl_bits_r};
				default:
				begin
					rdata <= 32'h0000_0000;
					rresp <= `T1TX_RESP_ERR;
				end
			endcase
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end
endmodule

// ==== dv/t1tx_props_properties.sv ====
// Purpose: bus and line timing checks on the output stage
// Assumes: bound to t1tx_out, one clock domain
// Notes:   control state is not shadowed here
`timescale 1ns/1ps
// ------------------------------
// Checker
// ------------------------------
module t1tx_props (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Register bus
	input logic        awvalid,
	input logic        awready,
	input logic        wvalid,
	input logic        wready,
	input logic        bvalid,
	input logic        bready,
	input logic [1:0]  bresp,
	input logic        arvalid,
	input logic        arready,
	input logic        rvalid,
	input logic        rready,
	input logic [31:0] rdata,
	// Line and link
	input logic        tx_line_clock,
	input logic        tx_positive_pulse,
	input logic        tx_negative_pulse,
	input logic        hdlc_last_loaded,
	input logic        datalink_service_request,
	input logic        datalink_shared_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Write answer two cycles after the take, read one; both hold
	a_b_after: assert property (
		awvalid && awready && wvalid && wready |=> ##1 bvalid)
		else $error("write answer late");
	a_r_after: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_aw_block: assert property (awvalid && awready |=> !awready)
		else $error("second write taken");
	// Line pins only move with a line clock edge
	a_pos_edge: assert property (
		$changed(tx_positive_pulse) |-> $changed(tx_line_clock))
		else $error("positive pin off edge");
	a_neg_edge: assert property (
		$changed(tx_negative_pulse) |-> $changed(tx_line_clock))
		else $error("negative pin off edge");
	a_sreq_set: assert property (
		hdlc_last_loaded |-> ##[1:2] datalink_service_request)
		else $error("service request missing");

	c_sreq: cover property ($rose(datalink_service_request));
	c_link: cover property ($rose(datalink_shared_out));
	c_fall: cover property ($fell(tx_positive_pulse));
endmodule

bind t1tx_out t1tx_props u_props (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.rready(rready), .rdata(rdata), .tx_line_clock(tx_line_clock),
	.tx_positive_pulse(tx_positive_pulse),
	.tx_negative_pulse(tx_negative_pulse),
	.hdlc_last_loaded(hdlc_last_loaded),
	.datalink_service_request(datalink_service_request),
	.datalink_shared_out(datalink_shared_out));

// ==== dv/t1tx_far_end.sv ====
// Purpose: far-side clocks and data-link bit source
// Assumes: source clocks run free
// Notes:   periods differ so the chosen source is visible
`timescale 1ns/1ps
// ------------------------------
// Far end model
// ------------------------------
module t1tx_far_end (
	// Data link
	input  logic       dl_clk,
	output logic       dl_bit = 0,
	output logic [7:0] sent = 0,
	// Source clocks
	output logic       clk_a = 0,
	output logic       clk_b = 1,
	output logic       clk_c = 0
);
	logic [2:0] cnt = 0;
	// Unrelated source clocks, 160, 200 and 240 ns
	always #80 clk_a = ~clk_a;
	always #100 clk_b = ~clk_b;
	always #120 clk_c = ~clk_c;
	// New bit after the fall, steady for the rise
	always @(negedge dl_clk)
	begin
		cnt <= cnt + 3'h1;
		dl_bit <= cnt[0] ^ cnt[2];
	end
	// What the device ought to capture
	always @(posedge dl_clk)
		sent <= {sent[6:0], dl_bit};
endmodule

// ==== dv/t1tx_out_tb_top.sv ====
// Purpose: directed checks of the line output stage
// Assumes: 100 MHz aclk, far-end model beside the block
// Notes:   line source 0 (160 ns) is used for data
`timescale 1ns/1ps
`include "t1tx_defines.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
	mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module t1tx_out_tb_top;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [3:0]  awaddr = 0;
	logic [3:0]  araddr = 0;
	logic [31:0] wdata = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic        rready = 0, src_valid = 0, dl_slot = 0, hll = 0, hbe = 0;
	logic [1:0]  src_bits = 0;
	wire         awready, wready, bvalid, arready, rvalid, src_ready;
	wire         tlc, tpp, tnp, dso, dsr, tci, rrc, btc, dsi;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [7:0]   sent;
	int          mismatches = 0, n_compared = 0, tr = 0, dr = 0;
	int          lo[4] = '{116, 92, 76, 27};
	int          hi[4] = '{124, 100, 84, 32};
	logic [8:0]  md[5] = '{9'h08, 9'h18, 9'h38, 9'h00, 9'h20};
	logic        lc, ld, rz = 0, fall_m = 0, single = 1;
	logic [1:0]  exp_q[$];
	logic [1:0]  pv;
	logic [31:0] rd_v;
	logic [1:0]  rd_r;
	logic [1:0]  wr_b;

	t1tx_out uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.src_valid(src_valid), .src_bits(src_bits),
		.src_ready(src_ready), .dl_slot(dl_slot),
		.hdlc_last_loaded(hll), .hdlc_buffer_empty(hbe),
		.tx_clock_input(tci), .recovered_rx_clock(rrc),
		.backplane_tx_clock(btc), .tx_line_clock(tlc),
		.tx_positive_pulse(tpp), .tx_negative_pulse(tnp),
		.datalink_serial_in(dsi), .datalink_shared_out(dso),
		.datalink_service_request(dsr));
	t1tx_far_end u_far (.dl_clk(dso), .dl_bit(dsi), .sent(sent),
		.clk_a(tci), .clk_b(rrc), .clk_c(btc));

	// 100 MHz clock
	always #5 aclk = ~aclk;

	// ------------------------------
	// Bus and stream tasks
	// ------------------------------
	task wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input [3:0] a, input [31:0] d);
	begin
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end
		while (!bvalid);
		wr_b = bresp;
		bready <= 0;
	end
	endtask
	task rd(input [3:0] a);
	begin
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 0;
		end
		while (!rvalid);
		rd_v = rdata;
		rd_r = rresp;
		rready <= 0;
	end
	endtask
	// Mode flags follow the control word for the monitor
	task cfg(input [8:0] m);
	begin
		single = !m[3];
		rz = m[3] & m[4];
		fall_m = m[5];
		wr(`T1TX_A_CTRL, {23'h0, m});
	end
	endtask
	// Held until the stage has room; the refusal is the fill limit
	task push(input [1:0] b);
	begin
		@(posedge aclk);
		src_valid <= 1;
		src_bits <= b;
		do
			@(posedge aclk);
		while (!src_ready);
		exp_q.push_back(single ? {1'b0, |b} : b);
		src_valid <= 0;
	end
	endtask
	task final_report;
	begin
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask

	// Line monitor: pairs at update edges, RZ clear at the other one
	always @(posedge aclk)
	begin
		lc <= tlc;
		ld <= dso;
		if (dso && !ld)
			dr++;
		if (tlc !== lc)
		begin
			tr++;
			pv = single ? {1'b0, tpp} : {tnp, tpp};
			if (tlc !== fall_m && pv != 0 && exp_q.size() > 0)
			begin
				`CHK("pair", exp_q[0], pv)
				void'(exp_q.pop_front());
			end
			else if (tlc === fall_m && rz)
				`CHK("rz", 2'b00, {tnp, tpp})
		end
	end

	// ------------------------------
	// Test sequence
	// ------------------------------
	initial
	begin
		wt(16);
		aresetn <= 1;
		rd(`T1TX_A_CTRL);
		`CHK("ctrl_rst", {23'h0, `T1TX_CTRL_RST}, rd_v)
		rd(4'hc);
		`CHK("bad_resp", `T1TX_RESP_ERR, rd_r)
		`CHK("bad_data", 32'h0, rd_v)
		wr(4'hc, 32'h0);
		`CHK("bad_wresp", `T1TX_RESP_ERR, wr_b)
		wr(`T1TX_A_CTRL, 32'h1ff);
		`CHK("wresp_ok", `T1TX_RESP_OK, wr_b)
		rd(`T1TX_A_CTRL);
		`CHK("ctrl_rw", 32'h1ff, rd_v)
		for (int s = 0; s < 4; s++)
		begin
			wr(`T1TX_A_CTRL, s < 3 ? s : 4);
			wt(100);
			tr = 0;
			wt(960);
			`CHK("rate", 1'b1, tr >= lo[s] && tr <= hi[s])
		end
		for (int k = 0; k < 5; k++)
		begin
			cfg(md[k]);
			for (int i = 0; i < 6; i++)
				push(i[0] ? 2'b10 : 2'b01);
			wt(200);
			`CHK("drained", 0, exp_q.size())
		end
		`CHK("flag_empty", 1'b1, tnp)
		cfg(9'h060);
		wt(60);
		`CHK("flag_full", 1'b0, tnp)
		cfg(9'h000);
		dr = 0;
		dl_slot <= 1;
		wt(400);
		dl_slot <= 0;
		wt(40);
		rd(`T1TX_A_DLBITS);
		`CHK("dl_bits", sent, rd_v[7:0])
		`CHK("dl_clk", 1'b1, dr >= 20)
		wr(`T1TX_A_CTRL, 32'h100);
		dl_slot <= 1;
		dr = 0;
		wt(300);
		`CHK("sf_low", 0, dr)
		dl_slot <= 0;
		wr(`T1TX_A_CTRL, 32'h80);
		hbe <= 1;
		wt(6);
		`CHK("no_udr", 1'b0, dso)
		hll <= 1;
		wt(1);
		hll <= 0;
		wt(6);
		`CHK("sreq", 1'b1, dsr)
		`CHK("udr", 1'b1, dso)
		hbe <= 0;
		wr(`T1TX_A_STAT, 32'h3);
		wt(4);
		`CHK("sreq_clr", 1'b0, dsr)
		`CHK("udr_clr", 1'b0, dso)
		final_report;
	end

	// Watchdog, about three times the expected run
	initial
	begin
		#200000;
		mismatches++;
		final_report;
	end
endmodule
